// ### hw/stop_after_start_flag_status_flags.sv
/*
  Two-wire slave with its upper status flags: address match, stop after
  start, general call handling, busy, NACK, receive FIFO and interrupt.
  Assumes SCL and SDA arrive asynchronously and are synchronised here; the
  bus master outside runs well below the system clock. Transmit data lives
  elsewhere; only its FIFO empty level comes in.
*/
`timescale 1ns/1ps
`include "stop_after_start_flag_cfg.svh"

module stop_after_start_flag_status_flags
  import stop_after_start_flag_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire stop_after_start_flag_req_t reg_req_i,
  output logic [15:0] reg_rdata_o,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic tx_empty_i,
  output logic irq_o
);

  localparam int DEPTH = `STOP_AFTER_START_FLAG_RX_DEPTH;

  // Synchroniser and edge history
  logic scl_s1_r, scl_s2_r, scl_d_r;
  logic sda_s1_r, sda_s2_r, sda_d_r;

  // Software registers
  logic [15:0] ctl_r, ctl_nxt;
  logic [7:0] id_r [4];
  logic [7:0] id_nxt [4];
  logic [7:0] alt_r, alt_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic irq_r, irq_nxt;

  // Status flags
  logic stop_r, stop_nxt;
  logic [1:0] gct_r, gct_nxt;
  logic gc_r, gc_nxt;
  logic busy_r, busy_nxt;
  logic nack_r, nack_nxt;
  logic ovf_r, ovf_nxt;
  logic [1:0] idx_r, idx_nxt;

  // Receive FIFO
  logic [7:0] mem_r [DEPTH];
  logic [7:0] mem_nxt [DEPTH];
  logic [1:0] wptr_r, wptr_nxt;
  logic [1:0] rptr_r, rptr_nxt;
  logic [2:0] cnt_r, cnt_nxt;

  // Bit engine
  stop_after_start_flag_state_t state_r, state_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic match_r, match_nxt;
  logic read_r, read_nxt;
  logic gcph_r, gcph_nxt;
  logic ack_r, ack_nxt;
  logic oe_r, oe_nxt;

  // Decoded bus conditions
  logic scl_rise, scl_fall, start_ev, stop_ev;
  // Per-cycle events and helpers
  logic sta_rd, rx_rd, pop, gc_clr, push, gc_rst, nak;
  logic [7:0] push_byte;
  logic [3:0] hit;
  logic [15:0] status;

  // Edge and condition detection on synchronised pins only
  assign scl_rise = scl_s2_r & ~scl_d_r;
  assign scl_fall = ~scl_s2_r & scl_d_r;
  assign start_ev = scl_s2_r & scl_d_r & ~sda_s2_r & sda_d_r;
  assign stop_ev = scl_s2_r & scl_d_r & sda_s2_r & ~sda_d_r;

  // Status word as software sees it
  always_comb begin
    status = 16'h0000;
    status[`STOP_AFTER_START_FLAG_STA_ID_LSB +: 2] = idx_r;
    status[`STOP_AFTER_START_FLAG_STA_STOP] = stop_r;
    status[`STOP_AFTER_START_FLAG_STA_GCT_LSB +: 2] = gct_r;
    status[`STOP_AFTER_START_FLAG_STA_GC] = gc_r;
    status[`STOP_AFTER_START_FLAG_STA_BUSY] = busy_r;
    status[`STOP_AFTER_START_FLAG_STA_NACK] = nack_r;
    status[`STOP_AFTER_START_FLAG_STA_OVF] = ovf_r;
    status[`STOP_AFTER_START_FLAG_STA_RXQ] = (cnt_r != 3'h0);
  end

  // Address comparison against the four slave IDs
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      hit[k] = (shift_r[7:1] == id_r[k][6:0]);
    end
  end

  // Next values of everything: register port, engine, flags, FIFO
  always_comb begin
    ctl_nxt = ctl_r;
    id_nxt = id_r;
    alt_nxt = alt_r;
    rdata_nxt = 16'h0000;
    stop_nxt = stop_r;
    gct_nxt = gct_r;
    gc_nxt = gc_r;
    busy_nxt = busy_r;
    nack_nxt = nack_r;
    ovf_nxt = ovf_r;
    idx_nxt = idx_r;
    mem_nxt = mem_r;
    wptr_nxt = wptr_r;
    rptr_nxt = rptr_r;
    cnt_nxt = cnt_r;
    state_nxt = state_r;
    bit_nxt = bit_r;
    shift_nxt = shift_r;
    match_nxt = match_r;
    read_nxt = read_r;
    gcph_nxt = gcph_r;
    ack_nxt = ack_r;
    oe_nxt = oe_r;
    push = 1'b0;
    push_byte = shift_r;
    gc_rst = 1'b0;
    nak = 1'b0;

    sta_rd = reg_req_i.rd && (reg_req_i.addr == `STOP_AFTER_START_FLAG_OFF_STATUS);
    rx_rd = reg_req_i.rd && (reg_req_i.addr == `STOP_AFTER_START_FLAG_OFF_RXDATA);
    pop = rx_rd && (cnt_r != 3'h0);
    gc_clr = reg_req_i.wr && (reg_req_i.addr == `STOP_AFTER_START_FLAG_OFF_CONTROL) &&
             reg_req_i.wdata[`STOP_AFTER_START_FLAG_CTL_GC_CLR];

    // Register writes; the clear bit is a strobe and never stored
    if (reg_req_i.wr) begin
      case (reg_req_i.addr)
        `STOP_AFTER_START_FLAG_OFF_CONTROL: ctl_nxt = reg_req_i.wdata & `STOP_AFTER_START_FLAG_CTL_WMASK;
        `STOP_AFTER_START_FLAG_OFF_ID0: id_nxt[0] = reg_req_i.wdata[7:0];
        `STOP_AFTER_START_FLAG_OFF_ID1: id_nxt[1] = reg_req_i.wdata[7:0];
        `STOP_AFTER_START_FLAG_OFF_ID2: id_nxt[2] = reg_req_i.wdata[7:0];
        `STOP_AFTER_START_FLAG_OFF_ID3: id_nxt[3] = reg_req_i.wdata[7:0];
        `STOP_AFTER_START_FLAG_OFF_ALT: alt_nxt = reg_req_i.wdata[7:0];
        default: ;
      endcase
    end

    // Register reads; unmapped offsets answer zero
    if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        `STOP_AFTER_START_FLAG_OFF_STATUS: rdata_nxt = status;
        `STOP_AFTER_START_FLAG_OFF_CONTROL: rdata_nxt = ctl_r;
        `STOP_AFTER_START_FLAG_OFF_ID0: rdata_nxt = {8'h00, id_r[0]};
        `STOP_AFTER_START_FLAG_OFF_ID1: rdata_nxt = {8'h00, id_r[1]};
        `STOP_AFTER_START_FLAG_OFF_ID2: rdata_nxt = {8'h00, id_r[2]};
        `STOP_AFTER_START_FLAG_OFF_ID3: rdata_nxt = {8'h00, id_r[3]};
        `STOP_AFTER_START_FLAG_OFF_ALT: rdata_nxt = {8'h00, alt_r};
        `STOP_AFTER_START_FLAG_OFF_RXDATA: rdata_nxt = {8'h00, mem_r[rptr_r]};
        default: rdata_nxt = 16'h0000;
      endcase
    end

    // Status read clears only the stop flag
    if (sta_rd) begin
      stop_nxt = 1'b0;
    end
    // Clear strobe drops general call flag and type together
    if (gc_clr) begin
      gc_nxt = 1'b0;
      gct_nxt = `STOP_AFTER_START_FLAG_GCT_NONE;
    end

    // Bit engine; start and stop override any state
    if (!ctl_r[`STOP_AFTER_START_FLAG_CTL_SLV_EN]) begin
      state_nxt = ST_IDLE;
      busy_nxt = 1'b0;
      match_nxt = 1'b0;
      oe_nxt = 1'b0;
    end else if (start_ev) begin
      busy_nxt = 1'b1;
      state_nxt = ST_ADDR;
      bit_nxt = 4'h0;
      gcph_nxt = 1'b0;
      oe_nxt = 1'b0;
    end else if (stop_ev) begin
      if (match_r) begin
        stop_nxt = 1'b1;
      end
      busy_nxt = 1'b0;
      match_nxt = 1'b0;
      gcph_nxt = 1'b0;
      oe_nxt = 1'b0;
      state_nxt = ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: ;
        ST_WAIT: ;
        ST_ADDR: begin
          if (scl_rise && bit_r != `STOP_AFTER_START_FLAG_BYTE_BITS) begin
            shift_nxt = {shift_r[6:0], sda_s2_r};
            bit_nxt = bit_r + 4'h1;
          end
          if (scl_fall && bit_r == `STOP_AFTER_START_FLAG_BYTE_BITS) begin
            if (hit != 4'h0) begin
              match_nxt = 1'b1;
              read_nxt = shift_r[0];
              // Lowest matching ID wins; ID3 reports 11
              if (hit[0]) begin
                idx_nxt = 2'h0;
              end else if (hit[1]) begin
                idx_nxt = 2'h1;
              end else if (hit[2]) begin
                idx_nxt = 2'h2;
              end else begin
                idx_nxt = 2'h3;
              end
              nak = ctl_r[`STOP_AFTER_START_FLAG_CTL_NACK] |
                    (shift_r[0] & tx_empty_i);
              nack_nxt = nak;
              ack_nxt = ~nak;
              oe_nxt = ~nak;
              state_nxt = ST_ACK;
            end else if (ctl_r[`STOP_AFTER_START_FLAG_CTL_GC_EN] &&
                         shift_r == `STOP_AFTER_START_FLAG_GC_ADDR) begin
              match_nxt = 1'b1;
              read_nxt = 1'b0;
              gcph_nxt = 1'b1;
              nak = ctl_r[`STOP_AFTER_START_FLAG_CTL_NACK];
              nack_nxt = nak;
              ack_nxt = ~nak;
              oe_nxt = ~nak;
              state_nxt = ST_ACK;
            end else begin
              // Not for us, whether first start or repeated
              busy_nxt = 1'b0;
              match_nxt = 1'b0;
              state_nxt = ST_WAIT;
            end
          end
        end
        ST_DATA: begin
          if (scl_rise && bit_r != `STOP_AFTER_START_FLAG_BYTE_BITS) begin
            shift_nxt = {shift_r[6:0], sda_s2_r};
            bit_nxt = bit_r + 4'h1;
          end
          if (scl_fall && bit_r == `STOP_AFTER_START_FLAG_BYTE_BITS) begin
            nak = ctl_r[`STOP_AFTER_START_FLAG_CTL_NACK];
            nack_nxt = nak;
            ack_nxt = ~nak;
            oe_nxt = ~nak;
            state_nxt = ST_ACK;
            if (gcph_r) begin
              // Command byte after the general call address
              gcph_nxt = 1'b0;
              gc_nxt = 1'b1;
              if (shift_r == `STOP_AFTER_START_FLAG_GC_RST_CMD) begin
                gct_nxt = `STOP_AFTER_START_FLAG_GCT_RST;
                gc_rst = 1'b1;
              end else if (shift_r == `STOP_AFTER_START_FLAG_GC_PROG_CMD) begin
                gct_nxt = `STOP_AFTER_START_FLAG_GCT_PROG;
              end else if (ctl_r[`STOP_AFTER_START_FLAG_CTL_HGC_EN] &&
                           shift_r == alt_r) begin
                gct_nxt = `STOP_AFTER_START_FLAG_GCT_ALT;
                push = 1'b1;
              end
            end else if (!nak) begin
              push = 1'b1;
            end
          end
        end
        ST_ACK: begin
          // Release SDA on the falling edge that ends the ACK slot
          if (scl_fall) begin
            oe_nxt = 1'b0;
            bit_nxt = 4'h0;
            if (ack_r && !read_r) begin
              state_nxt = ST_DATA;
            end else begin
              state_nxt = ST_WAIT;
            end
          end
        end
        default: state_nxt = ST_IDLE;
      endcase
    end

    // Receive FIFO; a push into a full FIFO is dropped and flagged
    if (push && cnt_r == 3'(DEPTH)) begin
      ovf_nxt = 1'b1;
    end else if (push || pop) begin
      ovf_nxt = 1'b0;
    end
    if (push && cnt_r != 3'(DEPTH)) begin
      mem_nxt[wptr_r] = push_byte;
      wptr_nxt = wptr_r + 2'h1;
    end
    if (pop) begin
      rptr_nxt = rptr_r + 2'h1;
    end
    cnt_nxt = cnt_r + {2'h0, push && cnt_r != 3'(DEPTH)} - {2'h0, pop};

    // General call reset: interface back to defaults, general call flag and type kept
    if (gc_rst) begin
      ctl_nxt = `STOP_AFTER_START_FLAG_CTL_RST;
      for (int k = 0; k < 4; k++) begin
        id_nxt[k] = `STOP_AFTER_START_FLAG_ID_RST;
      end
      alt_nxt = `STOP_AFTER_START_FLAG_ALT_RST;
      stop_nxt = 1'b0;
      nack_nxt = 1'b0;
      ovf_nxt = 1'b0;
      idx_nxt = 2'h0;
      wptr_nxt = 2'h0;
      rptr_nxt = 2'h0;
      cnt_nxt = 3'h0;
      // Type keeps the code loaded by this very command
    end

    // Level interrupt from the enabled sources
    irq_nxt = (stop_nxt & ctl_nxt[`STOP_AFTER_START_FLAG_CTL_STOP_IE]) |
              ((cnt_nxt != 3'h0) &
               ctl_nxt[`STOP_AFTER_START_FLAG_CTL_RX_IE]);
  end

  // Pin synchronisers; the first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s1_r <= scl_i;
      scl_s2_r <= scl_s1_r;
      scl_d_r <= scl_s2_r;
      sda_s1_r <= sda_i;
      sda_s2_r <= sda_s1_r;
      sda_d_r <= sda_s2_r;
    end
  end

  // State registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctl_r <= `STOP_AFTER_START_FLAG_CTL_RST;
      for (int k = 0; k < 4; k++) begin
        id_r[k] <= `STOP_AFTER_START_FLAG_ID_RST;
      end
      alt_r <= `STOP_AFTER_START_FLAG_ALT_RST;
      rdata_r <= 16'h0000;
      irq_r <= 1'b0;
      stop_r <= 1'b0;
      gct_r <= `STOP_AFTER_START_FLAG_GCT_NONE;
      gc_r <= 1'b0;
      busy_r <= 1'b0;
      nack_r <= 1'b0;
      ovf_r <= 1'b0;
      idx_r <= 2'h0;
      for (int k = 0; k < DEPTH; k++) begin
        mem_r[k] <= 8'h00;
      end
      wptr_r <= 2'h0;
      rptr_r <= 2'h0;
      cnt_r <= 3'h0;
      state_r <= ST_IDLE;
      bit_r <= 4'h0;
      shift_r <= 8'h00;
      match_r <= 1'b0;
      read_r <= 1'b0;
      gcph_r <= 1'b0;
      ack_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      ctl_r <= ctl_nxt;
      id_r <= id_nxt;
      alt_r <= alt_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
      stop_r <= stop_nxt;
      gct_r <= gct_nxt;
      gc_r <= gc_nxt;
      busy_r <= busy_nxt;
      nack_r <= nack_nxt;
      ovf_r <= ovf_nxt;
      idx_r <= idx_nxt;
      mem_r <= mem_nxt;
      wptr_r <= wptr_nxt;
      rptr_r <= rptr_nxt;
      cnt_r <= cnt_nxt;
      state_r <= state_nxt;
      bit_r <= bit_nxt;
      shift_r <= shift_nxt;
      match_r <= match_nxt;
      read_r <= read_nxt;
      gcph_r <= gcph_nxt;
      ack_r <= ack_nxt;
      oe_r <= oe_nxt;
    end
  end

  // Open-drain SDA: data level is always low, enable pulls
  assign sda_o = 1'b0;
  assign sda_oe_o = oe_r;
  assign reg_rdata_o = rdata_r;
  assign irq_o = irq_r;

endmodule

// ### shared/stop_after_start_flag_cfg.svh
/*
  Constants of the two-wire slave status block: register offsets, field
  positions, reset values and general call codes.
  Assumes inclusion by bare name from the package and the design module.
*/
// Operation
// - Match field reads 11 when the address equals the fourth slave ID and no lower one.
// - Status bit 10 sets on a stop after a matched start.
// - Stop interrupt fires while the stop flag and its enable are set.
// - Reading the status register clears the stop-after-start flag.
// - Bits 9:8 give general call type: none, reset, program, alternate.
// - A general call reset leaves the general call type untouched.
// - The general call type clears only through the clear bit.
// - Status bit 7 sets on any general call command.
// - A general call reset returns registers to defaults except the general call flag and type.
// - A hardware general call leaves its second byte in the receive FIFO.
// - The general call flag clears only through the clear bit.
// - Busy bit 6 sets as soon as a start condition appears.
// - Busy clears on address mismatch, stop, or repeated-start mismatch.
// - Bit 5 sets on a no-acknowledge for empty transmit or forced NACK.
// - Bit 4 sets when a byte is pushed into a full receive FIFO.
// - Bit 3 stays high while the receive FIFO holds a byte.
// - Receive interrupt fires while bit 3 and its enable are set.
// - Control bit 8 enables the stop interrupt.
// - Writing one to control bit 4 clears general call flag and type.
// - Control bit 7 forces a no-acknowledge; clear lets hardware decide.
// - Control bit 9 enables the receive interrupt.
`ifndef STOP_AFTER_START_FLAG_CFG_SVH
`define STOP_AFTER_START_FLAG_CFG_SVH

// Register offsets
`define STOP_AFTER_START_FLAG_OFF_STATUS 8'h00
`define STOP_AFTER_START_FLAG_OFF_CONTROL 8'h04
`define STOP_AFTER_START_FLAG_OFF_ID0 8'h08
`define STOP_AFTER_START_FLAG_OFF_ID1 8'h0c
`define STOP_AFTER_START_FLAG_OFF_ID2 8'h10
`define STOP_AFTER_START_FLAG_OFF_ID3 8'h14
`define STOP_AFTER_START_FLAG_OFF_ALT 8'h18
`define STOP_AFTER_START_FLAG_OFF_RXDATA 8'h1c

// Status field positions
`define STOP_AFTER_START_FLAG_STA_ID_LSB 11
`define STOP_AFTER_START_FLAG_STA_STOP 10
`define STOP_AFTER_START_FLAG_STA_GCT_LSB 8
`define STOP_AFTER_START_FLAG_STA_GC 7
`define STOP_AFTER_START_FLAG_STA_BUSY 6
`define STOP_AFTER_START_FLAG_STA_NACK 5
`define STOP_AFTER_START_FLAG_STA_OVF 4
`define STOP_AFTER_START_FLAG_STA_RXQ 3

// Control field positions
`define STOP_AFTER_START_FLAG_CTL_SLV_EN 0
`define STOP_AFTER_START_FLAG_CTL_GC_EN 2
`define STOP_AFTER_START_FLAG_CTL_HGC_EN 3
`define STOP_AFTER_START_FLAG_CTL_GC_CLR 4
`define STOP_AFTER_START_FLAG_CTL_NACK 7
`define STOP_AFTER_START_FLAG_CTL_STOP_IE 8
`define STOP_AFTER_START_FLAG_CTL_RX_IE 9
`define STOP_AFTER_START_FLAG_CTL_WMASK 16'h03ef

// Reset values
`define STOP_AFTER_START_FLAG_CTL_RST 16'h0000
`define STOP_AFTER_START_FLAG_ID_RST 8'h00
`define STOP_AFTER_START_FLAG_ALT_RST 8'h00

// General call codes and type values
`define STOP_AFTER_START_FLAG_GC_ADDR 8'h00
`define STOP_AFTER_START_FLAG_GC_RST_CMD 8'h06
`define STOP_AFTER_START_FLAG_GC_PROG_CMD 8'h04
`define STOP_AFTER_START_FLAG_GCT_NONE 2'h0
`define STOP_AFTER_START_FLAG_GCT_RST 2'h1
`define STOP_AFTER_START_FLAG_GCT_PROG 2'h2
`define STOP_AFTER_START_FLAG_GCT_ALT 2'h3

// Bits per byte on the wire, receive FIFO depth
`define STOP_AFTER_START_FLAG_BYTE_BITS 4'h8
`define STOP_AFTER_START_FLAG_RX_DEPTH 4

`endif

// ### shared/stop_after_start_flag_pkg.sv
/*
  Types of the two-wire slave status block: engine states and the
  register request carrier.
  Assumes the constants header sits in the include path.
*/
`include "stop_after_start_flag_cfg.svh"

package stop_after_start_flag_pkg;

  // Bit engine states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_DATA = 5'h04,
    ST_ACK = 5'h08,
    ST_WAIT = 5'h10
  } stop_after_start_flag_state_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } stop_after_start_flag_req_t;

endpackage

// ### tb/stop_after_start_flag_assertions.sv
/*
  Checker of the slave status block, watching its top ports only.
  Assumes a bind from the bench top and a free running clk_i.
*/
`timescale 1ns/1ps
`include "stop_after_start_flag_cfg.svh"
module stop_after_start_flag_assertions
  import stop_after_start_flag_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire stop_after_start_flag_req_t reg_req_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic tx_empty_i,
  input wire logic irq_o
);
  logic rd_sta, clr_wr, quiet, rd_q_r, gc_seen_r, gc_seen_nxt;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Request decode; quiet means both pins idle high
  assign rd_sta = reg_req_i.rd && reg_req_i.addr == `STOP_AFTER_START_FLAG_OFF_STATUS;
  assign clr_wr = reg_req_i.wr && reg_req_i.addr == `STOP_AFTER_START_FLAG_OFF_CONTROL
    && reg_req_i.wdata[`STOP_AFTER_START_FLAG_CTL_GC_CLR];
  assign quiet = scl_i && sda_i;
  // Once software saw the gc flag, only a clear may drop it
  always_comb begin
    gc_seen_nxt = gc_seen_r;
    if (clr_wr) begin
      gc_seen_nxt = 1'b0;
    end else if (rd_q_r && reg_rdata_o[`STOP_AFTER_START_FLAG_STA_GC]) begin
      gc_seen_nxt = 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      gc_seen_r <= 1'b0;
      rd_q_r <= 1'b0;
    end else begin
      gc_seen_r <= gc_seen_nxt;
      rd_q_r <= rd_sta;
    end
  end
  AST_RDATA_ZERO: assert property (
    !$past(reg_req_i.rd) |-> reg_rdata_o == 16'h0000)
    else $error("read data outside a read answer");
  AST_RSVD_ZERO: assert property (
    rd_q_r |-> reg_rdata_o[15:13] == 3'h0 && reg_rdata_o[2:0] == 3'h0)
    else $error("reserved status bits set");
  AST_STOP_RD_CLR: assert property (
    quiet[*4] ##0 rd_sta ##1 reg_rdata_o[10] ##1 rd_sta
    |=> !reg_rdata_o[10])
    else $error("stop flag survived a status read");
  AST_OE_SCL_HIGH: assert property (
    scl_i[*4] |-> $stable(sda_oe_o))
    else $error("acknowledge drive moved while clock high");
  AST_OVF_RXQ: assert property (
    rd_q_r && reg_rdata_o[4] |-> reg_rdata_o[3])
    else $error("overflow with empty receive fifo");
  AST_GCT_FLAG: assert property (
    rd_q_r && reg_rdata_o[9:8] != 2'h0 |-> reg_rdata_o[7])
    else $error("gc type without gc flag");
  AST_GC_CLEAR: assert property (
    quiet[*4] ##0 clr_wr ##2 rd_sta |=> reg_rdata_o[9:7] == 3'h0)
    else $error("gc fields not cleared");
  AST_GC_STICKY: assert property (
    rd_q_r && gc_seen_r |-> reg_rdata_o[7])
    else $error("gc flag dropped without clear");
  AST_IRQ_QUIET: assert property (
    quiet[*4] ##0 rd_sta ##1 (!reg_rdata_o[10] && !reg_rdata_o[3])
    |=> !irq_o)
    else $error("interrupt without a source");
  cover property (rd_q_r && reg_rdata_o[12:11] == 2'h3);
  cover property (rd_q_r && reg_rdata_o[9:8] == 2'h3);
  cover property (rd_q_r && reg_rdata_o[4]);
endmodule

// ### tb/stop_after_start_flag_bus_master.sv
/*
  Behavioural two-wire bus master facing the slave block.
  Assumes an open drain data line with a pull-up; SCL rests high.
*/
`timescale 1ns/1ps
module stop_after_start_flag_bus_master (
  input wire logic dev_oe_i,
  output logic scl_o,
  output logic sda_o
);
  logic pull_low;
  // Wired line: either side pulls low, else pull-up wins
  assign sda_o = !(pull_low || dev_oe_i);
  initial begin
    scl_o = 1'b1;
    pull_low = 1'b0;
  end
  // Start or repeated start, clock left low
  task automatic start_cond();
    #8 pull_low = 1'b0;
    #24 scl_o = 1'b1;
    #16 pull_low = 1'b1;
    #16 scl_o = 1'b0;
  endtask
  // Data moves 8 ns after the clock fall to keep hold time
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #8 pull_low = !b[i];
      #24 scl_o = 1'b1;
      #32 scl_o = 1'b0;
    end
    #8 pull_low = 1'b0;
    #24 scl_o = 1'b1;
    #16 ack = !sda_o;
    #16 scl_o = 1'b0;
  endtask
  task automatic stop_cond();
    #8 pull_low = 1'b1;
    #24 scl_o = 1'b1;
    #16 pull_low = 1'b0;
    #16;
  endtask
endmodule

// ### tb/testbench.sv
/*
  Self-checking bench of the slave status block.
  Assumes the bus master model and the checker are compiled first.
*/
`timescale 1ns/1ps
`include "stop_after_start_flag_cfg.svh"
module testbench import stop_after_start_flag_pkg::*;;
  logic clk_i, rst_n_i, tx_empty_i, sda_oe_o, sda_o, irq_o, scl, sda, ack;
  stop_after_start_flag_req_t req;
  logic [15:0] rdata, rd;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  // 200 MHz system clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = !clk_i;
  end
  stop_after_start_flag_status_flags u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .reg_req_i(req), .reg_rdata_o(rdata), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .tx_empty_i(tx_empty_i),
    .irq_o(irq_o));
  stop_after_start_flag_bus_master u_m (.dev_oe_i(sda_oe_o), .scl_o(scl), .sda_o(sda));
  task automatic print_verdict();
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Hang guard, far above the few thousand cycles needed
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    req.wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rdr(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_i);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic sta(input logic [15:0] m, e);
    rdr(`STOP_AFTER_START_FLAG_OFF_STATUS, rd);
    check("status", rd & m, e);
  endtask
  task automatic frame(input logic [7:0] a, input int n, input logic [7:0] d);
    logic k;
    u_m.start_cond();
    u_m.send_byte(a, ack);
    for (int i = 0; i < n; i++) begin
      u_m.send_byte(d + 8'(i), k);
    end
    u_m.stop_cond();
    repeat (10) @(posedge clk_i);
  endtask
  task automatic t_reset();
    sta(16'hffff, 16'h0000);
    rdr(`STOP_AFTER_START_FLAG_OFF_CONTROL, rd);
    check("control", rd, 16'h0000);
    rdr(8'h3c, rd);
    check("unmapped", rd, 16'h0000);
    check("irq", 16'(irq_o), 16'h0000);
    check("sda level", 16'(sda_o), 16'h0000);
  endtask
  task automatic t_match();
    wr(`STOP_AFTER_START_FLAG_OFF_ID0, 16'h0011);
    wr(`STOP_AFTER_START_FLAG_OFF_ID1, 16'h0022);
    wr(`STOP_AFTER_START_FLAG_OFF_ID2, 16'h0033);
    wr(`STOP_AFTER_START_FLAG_OFF_ID3, 16'h0044);
    wr(`STOP_AFTER_START_FLAG_OFF_CONTROL, 16'h0301);
    u_m.start_cond();
    repeat (10) @(posedge clk_i);
    sta(16'h0040, 16'h0040);
    u_m.send_byte({7'h44, 1'b0}, ack);
    check("ack", 16'(ack), 16'h0001);
    u_m.send_byte(8'ha5, ack);
    u_m.stop_cond();
    repeat (10) @(posedge clk_i);
    check("irq", 16'(irq_o), 16'h0001);
    sta(16'h1c48, 16'h1c08);
    sta(16'h0400, 16'h0000);
    repeat (3) @(posedge clk_i);
    check("irq", 16'(irq_o), 16'h0001);
    rdr(`STOP_AFTER_START_FLAG_OFF_RXDATA, rd);
    check("rx byte", rd, 16'h00a5);
    repeat (3) @(posedge clk_i);
    check("irq", 16'(irq_o), 16'h0000);
    sta(16'h0008, 16'h0000);
  endtask
  task automatic t_miss();
    wr(`STOP_AFTER_START_FLAG_OFF_CONTROL, 16'h0001);
    frame({7'h33, 1'b0}, 0, 8'h00);
    check("irq", 16'(irq_o), 16'h0000);
    sta(16'h1c00, 16'h1400);
    u_m.start_cond();
    u_m.send_byte({7'h55, 1'b0}, ack);
    check("ack", 16'(ack), 16'h0000);
    repeat (10) @(posedge clk_i);
    sta(16'h0040, 16'h0000);
    u_m.stop_cond();
    repeat (10) @(posedge clk_i);
    sta(16'h0400, 16'h0000);
  endtask
  // Five bytes into a four deep fifo; the fifth is dropped
  task automatic t_ovf();
    frame({7'h11, 1'b0}, 5, 8'h10);
    sta(16'h1818, 16'h0018);
    check("irq", 16'(irq_o), 16'h0000);
    for (int i = 0; i < 4; i++) begin
      rdr(`STOP_AFTER_START_FLAG_OFF_RXDATA, rd);
      check("rx byte", rd, 16'h0010 + 16'(i));
    end
    sta(16'h0018, 16'h0000);
  endtask
  task automatic t_nack();
    @(posedge clk_i);
    tx_empty_i <= 1'b1;
    frame({7'h22, 1'b1}, 0, 8'h00);
    check("ack", 16'(ack), 16'h0000);
    sta(16'h0020, 16'h0020);
    @(posedge clk_i);
    tx_empty_i <= 1'b0;
    wr(`STOP_AFTER_START_FLAG_OFF_CONTROL, 16'h0081);
    frame({7'h22, 1'b0}, 0, 8'h00);
    check("ack", 16'(ack), 16'h0000);
    sta(16'h0020, 16'h0020);
    wr(`STOP_AFTER_START_FLAG_OFF_CONTROL, 16'h0001);
    frame({7'h22, 1'b0}, 0, 8'h00);
    check("ack", 16'(ack), 16'h0001);
    sta(16'h0020, 16'h0000);
  endtask
  task automatic t_gc();
    logic [7:0] cmd [2] = '{8'h04, 8'h55};
    logic [15:0] typ [2] = '{16'h0200, 16'h0300};
    wr(`STOP_AFTER_START_FLAG_OFF_ALT, 16'h0055);
    for (int i = 0; i < 2; i++) begin
      wr(`STOP_AFTER_START_FLAG_OFF_CONTROL, 16'h000d);
      frame(8'h00, 1, cmd[i]);
      sta(16'h0380, typ[i] | 16'h0080);
      if (i == 1) begin
        rdr(`STOP_AFTER_START_FLAG_OFF_RXDATA, rd);
        check("rx byte", rd, 16'h0055);
      end
      wr(`STOP_AFTER_START_FLAG_OFF_CONTROL, 16'h001d);
      sta(16'h0380, 16'h0000);
    end
    frame(8'h00, 1, 8'h06);
    sta(16'h0380, 16'h0180);
    rdr(`STOP_AFTER_START_FLAG_OFF_CONTROL, rd);
    check("control", rd, 16'h0000);
    rdr(`STOP_AFTER_START_FLAG_OFF_ID3, rd);
    check("id3", rd, 16'h0000);
    sta(16'h0380, 16'h0180);
    wr(`STOP_AFTER_START_FLAG_OFF_CONTROL, 16'h0010);
    sta(16'h0380, 16'h0000);
  endtask
  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    tx_empty_i = 1'b0;
    req = '0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_match();
    t_miss();
    t_ovf();
    t_nack();
    t_gc();
    print_verdict();
  end
endmodule
bind stop_after_start_flag_status_flags stop_after_start_flag_assertions u_chk (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .tx_empty_i(tx_empty_i), .irq_o(irq_o));
